/* File: rtl/pcg_pkg.sv */
// Purpose: constants for the peripheral clock gating block
// Assumes: apb slave with 32-bit data, byte addresses
// Notes:   offsets are byte addresses of aligned words
package pcg_pkg;
  localparam int          PCG_AW              = 13;
  localparam logic [12:0] PCG_MAIN_OFFSET     = 13'h103C;
  localparam logic [12:0] PCG_XFER_OFFSET     = 13'h1040;
  localparam int          PCG_RTC_BIT         = 29;
  localparam int          PCG_ADC_BIT         = 27;
  localparam int          PCG_SECOND_TIMER_PWM_CLOCK_GATE_BIT        = 25;
  localparam int          PCG_FIRST_TIMER_PWM_CLOCK_GATE_BIT        = 24;
  localparam int          PCG_PIT_BIT         = 23;
  localparam int          PCG_MUX_BIT         = 1;
  localparam int          PCG_FLASH_BIT       = 0;
  localparam int          PCG_DMA_BIT         = 8;
  localparam logic [31:0] PCG_MAIN_MASK       = 32'h2B80_0003;
  localparam logic [31:0] PCG_XFER_MASK       = 32'h0000_0100;
  localparam logic [31:0] PCG_MAIN_RESET      = 32'h0000_0001;
  localparam logic [31:0] PCG_XFER_RESET      = 32'h0000_0100;
endpackage : pcg_pkg

/* File: rtl/pcg_gate_reg.sv */
// Purpose: one masked 32-bit gating register
// Assumes: write strobe is a one-cycle pulse
// Notes:   bits outside the mask stay zero
`timescale 1ns/100ps
`default_nettype none
module pcg_gate_reg #(
  parameter logic [31:0] MASK  = 32'h0,
  parameter logic [31:0] RESET = 32'h0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] q
);
  logic [31:0] q_r;
  logic [31:0] q_nxt;
  assign q_nxt = wr_en ? (wr_data & MASK) : q_r;
  assign q     = q_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= RESET & MASK;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule : pcg_gate_reg
`default_nettype wire

/* File: rtl/pcg_top.sv */
// Purpose: apb slave holding two clock-gating registers
// Assumes: zero wait states, pslverr on unmapped address
// Notes:   gate outputs come straight from flip-flops
`timescale 1ns/100ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [PCG_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   rtc_access_enable,
  output logic                   converter_clock_gate,
  output logic                   second_timer_pwm_clock_gate,
  output logic                   first_timer_pwm_clock_gate,
  output logic                   periodic_timer_clock_gate,
  output logic                   request_mux_clock_gate,
  output logic                   flash_clock_gate,
  output logic                   dma_clock_gate,
  output logic                   flash_read_allowed,
  output logic                   low_power_block
);
  // ****************
  // decode
  // ****************
  logic        setup;
  logic        hit_main;
  logic        hit_xfer;
  logic        mapped;
  logic        wr_main;
  logic        wr_xfer;
  logic [31:0] strb_mask;
  logic [31:0] main_q;
  logic [31:0] xfer_q;
  logic [31:0] main_wdata;
  logic [31:0] xfer_wdata;
  logic [31:0] rd_mux;
  logic        ready_r;
  logic [31:0] prdata_r;
  logic        slverr_r;

  assign setup     = psel && !penable && !ready_r;
  assign hit_main  = (paddr == PCG_MAIN_OFFSET);
  assign hit_xfer  = (paddr == PCG_XFER_OFFSET);
  assign mapped    = hit_main || hit_xfer;
  assign wr_main   = setup && pwrite && hit_main;
  assign wr_xfer   = setup && pwrite && hit_xfer;
  assign strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  // keep unstrobed lanes; reserved bits masked in register
  assign main_wdata = (pwdata & strb_mask) | (main_q & ~strb_mask);
  assign xfer_wdata = (pwdata & strb_mask) | (xfer_q & ~strb_mask);
  // reserved bits read zero
  assign rd_mux = hit_main ? (main_q & PCG_MAIN_MASK) :
                  hit_xfer ? (xfer_q & PCG_XFER_MASK) : 32'h0000_0000;

  // ****************
  // registers
  // ****************
  pcg_gate_reg #(
    .MASK  (PCG_MAIN_MASK),
    .RESET (PCG_MAIN_RESET)
  ) u_main (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_main),
    .wr_data (main_wdata),
    .q       (main_q)
  );

  pcg_gate_reg #(
    .MASK  (PCG_XFER_MASK),
    .RESET (PCG_XFER_RESET)
  ) u_xfer (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_xfer),
    .wr_data (xfer_wdata),
    .q       (xfer_q)
  );

  // ****************
  // apb answer
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r  <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      ready_r  <= setup;
      prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      slverr_r <= setup && !mapped;
    end
  end
  assign pready  = ready_r;
  assign prdata  = prdata_r;
  assign pslverr = slverr_r;

  // ****************
  // gate outputs
  // ****************
  assign rtc_access_enable           = main_q[PCG_RTC_BIT];
  assign converter_clock_gate        = main_q[PCG_ADC_BIT];
  assign second_timer_pwm_clock_gate = main_q[PCG_SECOND_TIMER_PWM_CLOCK_GATE_BIT];
  assign first_timer_pwm_clock_gate  = main_q[PCG_FIRST_TIMER_PWM_CLOCK_GATE_BIT];
  assign periodic_timer_clock_gate   = main_q[PCG_PIT_BIT];
  assign request_mux_clock_gate      = main_q[PCG_MUX_BIT];
  assign flash_clock_gate            = main_q[PCG_FLASH_BIT];
  assign dma_clock_gate              = xfer_q[PCG_DMA_BIT];
  // flash reads stay served whatever the flash gate holds
  logic fra_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fra_r <= 1'b1;
    end else begin
      fra_r <= 1'b1;
    end
  end
  assign flash_read_allowed          = fra_r;

  // low-power entry blocked while flash clock gated
  logic lp_block_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_block_r <= 1'b0;
    end else begin
      lp_block_r <= ~main_wdata[PCG_FLASH_BIT] & wr_main | ~main_q[PCG_FLASH_BIT] & ~wr_main;
    end
  end
  assign low_power_block = lp_block_r;
endmodule : pcg_top
`default_nettype wire

/* File: testbench/pcg_properties.sv */
// Purpose: apb and gate checks
// Assumes: zero wait states
// Notes:   bound to pcg_top
`timescale 1ns/100ps
`default_nettype none
module pcg_properties
  import pcg_pkg::*;
(
  input wire logic              pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [PCG_AW-1:0] paddr,
  input wire logic [31:0]       pwdata, prdata,
  input wire logic [3:0]        pstrb,
  input wire logic              rtc_access_enable, flash_clock_gate, dma_clock_gate, low_power_block
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_s(a, l);
    psel && !penable && pwrite && paddr == a && pstrb[l];
  endsequence
  sequence rd_s(a);
    pready && psel && !pwrite && paddr == a;
  endsequence
  low_power_a: assert property (low_power_block == !flash_clock_gate)
    else $error("low power block wrong");
  main_rsv_a: assert property (rd_s(PCG_MAIN_OFFSET) |-> !(prdata & ~PCG_MAIN_MASK))
    else $error("main reserved bit set");
  xfer_rsv_a: assert property (rd_s(PCG_XFER_OFFSET) |-> !(prdata & ~PCG_XFER_MASK))
    else $error("dma reserved bit set");
  flash_wr_a: assert property (wr_s(PCG_MAIN_OFFSET, 0) |=> flash_clock_gate == $past(pwdata[0]))
    else $error("flash gate not written");
  rtc_wr_a: assert property (wr_s(PCG_MAIN_OFFSET, 3) |=> rtc_access_enable == $past(pwdata[29]))
    else $error("rtc enable not written");
  dma_wr_a: assert property (wr_s(PCG_XFER_OFFSET, 1) |=> dma_clock_gate == $past(pwdata[8]))
    else $error("dma gate not written");
  gate_hold_a: assert property (!(psel && !penable && pwrite) |=>
    $stable({rtc_access_enable, flash_clock_gate, dma_clock_gate}))
    else $error("gate changed without write");
  bad_addr_a: assert property (psel && !penable && paddr != PCG_MAIN_OFFSET && paddr != PCG_XFER_OFFSET
    |=> pready && pslverr)
    else $error("unmapped not refused");
endmodule : pcg_properties
bind pcg_top pcg_properties pcg_properties_i (.*);
`default_nettype wire

/* File: testbench/pcg_top_tb_top.sv */
// Purpose: bench for pcg_top
// Assumes: zero wait apb slave
// Notes:   notes queued by driver, checked on pready
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module pcg_top_tb_top;
  import pcg_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [12:0] paddr = '0;
  logic [12:0] adr[3] = '{PCG_MAIN_OFFSET, PCG_XFER_OFFSET, 13'h1044};
  logic [31:0] pwdata = '0, prdata, m_r, x_r;
  logic [3:0]  pstrb = '0;
  logic        pready, pslverr, rtc, cnv, tm2, tm1, per, mux, fl, dma, fra, lpb;
  logic [42:0] q[$];
  int          fail_count = 0, check_count = 0;
  always #10 pclk = ~pclk;
  pcg_top pcg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .rtc_access_enable(rtc), .converter_clock_gate(cnv), .second_timer_pwm_clock_gate(tm2),
    .first_timer_pwm_clock_gate(tm1), .periodic_timer_clock_gate(per), .request_mux_clock_gate(mux),
    .flash_clock_gate(fl), .dma_clock_gate(dma), .flash_read_allowed(fra), .low_power_block(lpb));
  function automatic logic [42:0] note(logic [12:0] a, logic w);
    logic [31:0] d;
    d = w ? '0 : a == PCG_MAIN_OFFSET ? m_r : a == PCG_XFER_OFFSET ? x_r : '0;
    return {a != PCG_MAIN_OFFSET && a != PCG_XFER_OFFSET, 1'b1, !m_r[0], m_r[29], m_r[27], m_r[25],
      m_r[24], m_r[23], m_r[1], m_r[0], x_r[8], d};
  endfunction : note
  task automatic xfer(logic w, logic [12:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    for (int i = 0; i < 4; i++) begin
      if (w && s[i] && a == PCG_MAIN_OFFSET) m_r[8*i+:8] = d[8*i+:8];
      if (w && s[i] && a == PCG_XFER_OFFSET) x_r[8*i+:8] = d[8*i+:8];
    end
    m_r &= PCG_MAIN_MASK;
    x_r &= PCG_XFER_MASK;
    q.push_back(note(a, w));
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : xfer
  always @(posedge pclk) if (pready === 1'b1) begin
    `CHK({pslverr, fra, lpb, rtc, cnv, tm2, tm1, per, mux, fl, dma, prdata}, q.pop_front())
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'h4A55));
    for (int t = 0; t < 2; t++) begin
      {m_r, x_r} = {PCG_MAIN_RESET, PCG_XFER_RESET};
      @(posedge pclk) presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (adr[k]) xfer(0, adr[k], '0, 4'h0);
      foreach (adr[k]) for (int v = 0; v < 2; v++) begin
        xfer(1, adr[k], {32{~v[0]}}, 4'hF);
        xfer(0, adr[k], '0, 4'h0);
      end
      repeat (40) begin
        logic [12:0] ra;
        ra = adr[$urandom_range(2)];
        xfer(1, ra, $urandom, 4'($urandom));
        xfer(0, ra, '0, 4'h0);
      end
      $display("reset pass %0d done", t);
    end
    test_done();
  end
endmodule : pcg_top_tb_top
`default_nettype wire
